// [src/dlis_pkg.sv]
// package of offsets, fields and reset values for the data link event status logic
package dlis_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] DLIS_STATUS_OFS = 8'h00;
  localparam logic [7:0] DLIS_ENABLE_OFS = 8'h01;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int DLIS_BIT_IDLE = 0;
  localparam int DLIS_BIT_ABORT = 1;
  localparam int DLIS_BIT_FCS = 2;
  localparam int DLIS_BIT_RX_EOM = 3;
  localparam int DLIS_BIT_TX_EOM = 4;
  localparam int DLIS_BIT_RX_SOM = 5;
  localparam int DLIS_BIT_TX_SOM = 6;
  localparam int DLIS_BIT_MSG_TYPE = 7;

  // ----------------------------------------------------------------
  // reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] DLIS_STATUS_RST = 8'h00;
  localparam logic [7:0] DLIS_ENABLE_RST = 8'h00;
  localparam logic [6:0] DLIS_EVENT_RST = 7'h00;
  localparam logic [7:0] DLIS_ENABLE_MASK = 8'h7F;

endpackage : dlis_pkg

// [src/dlis_top.sv]
// data link event status and enable registers with interrupt request
`timescale 1ns/1ps
module dlis_top
  import dlis_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // frame controller events, one-cycle pulses
  input wire logic i_rx_message_complete,
  input wire logic i_frame_check_mismatch,
  input wire logic i_rx_abort_seen,
  input wire logic i_rx_flag_octet_seen,
  input wire logic i_tx_message_complete,
  input wire logic i_rx_message_begin,
  input wire logic i_tx_message_begin,
  // message type level from the receive controller
  input wire logic i_rx_msg_type,
  // interrupt request
  output logic o_data_link_irq
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [6:0] event_q;
  logic [6:0] event_d;
  logic [6:0] enable_q;
  logic [6:0] enable_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic irq_q;
  logic irq_d;
  logic [6:0] event_in;
  logic [6:0] read_clear;
  logic [7:0] status_view;
  logic [7:0] enable_view;
  logic sel_status;
  logic sel_enable;
  logic status_rd;
  logic enable_wr;
  logic [6:0] irq_gated;

  assign sel_status = (i_reg_addr == DLIS_STATUS_OFS);
  assign sel_enable = (i_reg_addr == DLIS_ENABLE_OFS);
  assign status_rd = i_reg_rd & sel_status;
  assign enable_wr = i_reg_wr & sel_enable;

  // ----------------------------------------------------------------
  // event collection
  // ----------------------------------------------------------------
  assign event_in[DLIS_BIT_RX_EOM] = i_rx_message_complete;
  assign event_in[DLIS_BIT_FCS] = i_frame_check_mismatch;
  assign event_in[DLIS_BIT_ABORT] = i_rx_abort_seen;
  assign event_in[DLIS_BIT_IDLE] = i_rx_flag_octet_seen;
  assign event_in[DLIS_BIT_TX_SOM] = i_tx_message_begin;
  assign event_in[DLIS_BIT_RX_SOM] = i_rx_message_begin;
  assign event_in[DLIS_BIT_TX_EOM] = i_tx_message_complete;

  // a read clears only what it returned; a new event in that cycle stays set
  assign read_clear = status_rd ? event_q : 7'h00;
  assign event_d = (event_q & ~read_clear) | event_in;

  // ----------------------------------------------------------------
  // enable register
  // ----------------------------------------------------------------
  assign enable_d = enable_wr ? i_reg_wdata[6:0] : enable_q;

  // ----------------------------------------------------------------
  // read data and interrupt
  // ----------------------------------------------------------------
  assign status_view = {i_rx_msg_type, event_q};
  assign enable_view = {1'b0, enable_q};
  assign rdata_d = !i_reg_rd ? 8'h00 : sel_status ? status_view : sel_enable ? enable_view : 8'h00;
  assign irq_gated = event_d & enable_d;
  assign irq_d = |irq_gated;

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      event_q <= DLIS_EVENT_RST;
    end else begin
      event_q <= event_d;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      enable_q <= DLIS_ENABLE_RST[6:0];
    end else begin
      enable_q <= enable_d;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata_q <= DLIS_STATUS_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_data_link_irq = irq_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_status_read;
    i_reg_rd && sel_status;
  endsequence

  sequence s_enable_write;
    i_reg_wr && sel_enable;
  endsequence

  sequence s_enable_read;
    i_reg_rd && sel_enable;
  endsequence

  a_rx_eom_set: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_rx_message_complete |=> event_q[DLIS_BIT_RX_EOM])
    else $error("receive complete event not latched");
  a_fcs_set: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_frame_check_mismatch |=> event_q[DLIS_BIT_FCS])
    else $error("frame check event not latched");
  a_abort_set: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_rx_abort_seen |=> event_q[DLIS_BIT_ABORT])
    else $error("abort event not latched");
  a_idle_set: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_rx_flag_octet_seen |=> event_q[DLIS_BIT_IDLE])
    else $error("flag octet event not latched");
  a_read_clears: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    s_status_read ##0 (event_in == 7'h00) |=> (event_q == 7'h00))
    else $error("status read did not clear events");
  a_read_returns: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    s_status_read |=> (o_reg_rdata[6:0] == $past(event_q)))
    else $error("status read returned wrong value");
  a_no_spurious: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (event_in == 7'h00) && !i_reg_rd |=> (event_q == $past(event_q)))
    else $error("event bit changed without cause");
  a_tx_begin_set: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_tx_message_begin && i_tx_message_complete |=> event_q[DLIS_BIT_TX_SOM] && event_q[DLIS_BIT_TX_EOM])
    else $error("transmit events not latched");
  a_enable_write: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    s_enable_write |=> (enable_q == $past(i_reg_wdata[6:0])))
    else $error("enable write not stored");
  a_irq_gate: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_data_link_irq == |(event_q & enable_q))
    else $error("interrupt does not match gated status");
  a_reserved_zero: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_reg_rd && sel_enable |=> !o_reg_rdata[7])
    else $error("reserved enable bit read nonzero");

  // ----------------------------------------------------------------
  // reset, read data and enable hold
  // ----------------------------------------------------------------
  a_reset_clear: assert property (@(posedge i_core_clk)
    i_sys_rst |-> (event_q == DLIS_EVENT_RST) && (enable_q == DLIS_ENABLE_RST[6:0]) && !o_data_link_irq)
    else $error("state not cleared during reset");

  a_reset_rdata: assert property (@(posedge i_core_clk)
    i_sys_rst |-> (o_reg_rdata == DLIS_STATUS_RST))
    else $error("read data not cleared during reset");

  a_rdata_idle: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !i_reg_rd |=> (o_reg_rdata == 8'h00))
    else $error("read data present without a read");

  a_msg_type_live: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    s_status_read |=> (o_reg_rdata[DLIS_BIT_MSG_TYPE] == $past(i_rx_msg_type)))
    else $error("message type bit not read live");

  a_enable_read: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    s_enable_read |=> (o_reg_rdata == {1'b0, $past(enable_q)}))
    else $error("enable read returned wrong value");

  a_enable_hold: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !enable_wr |=> (enable_q == $past(enable_q)))
    else $error("enable changed without a write");

  a_unmapped_write: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_reg_wr && !sel_enable |=> (enable_q == $past(enable_q)))
    else $error("write elsewhere changed enable");

  a_unmapped_read: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_reg_rd && !sel_status && !sel_enable |=> (o_reg_rdata == 8'h00))
    else $error("unmapped read returned nonzero");

  // ----------------------------------------------------------------
  // event latching
  // ----------------------------------------------------------------
  a_tx_som_set: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_tx_message_begin |=> event_q[DLIS_BIT_TX_SOM])
    else $error("transmit begin event not latched");

  a_rx_som_set: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_rx_message_begin |=> event_q[DLIS_BIT_RX_SOM])
    else $error("receive begin event not latched");

  a_tx_eom_set: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_tx_message_complete |=> event_q[DLIS_BIT_TX_EOM])
    else $error("transmit complete event not latched");

  a_status_write_void: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_reg_wr && sel_status && !i_reg_rd && (event_in == 7'h00) |=> (event_q == $past(event_q)))
    else $error("status write changed events");

  // ----------------------------------------------------------------
  // status bits hold until read
  // ----------------------------------------------------------------
  a_rx_eom_hold: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    event_q[DLIS_BIT_RX_EOM] && !status_rd |=> event_q[DLIS_BIT_RX_EOM])
    else $error("receive complete bit lost before read");

  a_fcs_hold: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    event_q[DLIS_BIT_FCS] && !status_rd |=> event_q[DLIS_BIT_FCS])
    else $error("frame check bit lost before read");

  a_abort_hold: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    event_q[DLIS_BIT_ABORT] && !status_rd |=> event_q[DLIS_BIT_ABORT])
    else $error("abort bit lost before read");

  a_idle_hold: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    event_q[DLIS_BIT_IDLE] && !status_rd |=> event_q[DLIS_BIT_IDLE])
    else $error("flag octet bit lost before read");

  a_tx_eom_hold: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    event_q[DLIS_BIT_TX_EOM] && !status_rd |=> event_q[DLIS_BIT_TX_EOM])
    else $error("transmit complete bit lost before read");

  a_rx_som_hold: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    event_q[DLIS_BIT_RX_SOM] && !status_rd |=> event_q[DLIS_BIT_RX_SOM])
    else $error("receive begin bit lost before read");

  a_tx_som_hold: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    event_q[DLIS_BIT_TX_SOM] && !status_rd |=> event_q[DLIS_BIT_TX_SOM])
    else $error("transmit begin bit lost before read");

  // ----------------------------------------------------------------
  // clear on read
  // ----------------------------------------------------------------
  a_rx_eom_clear: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    status_rd && !event_in[DLIS_BIT_RX_EOM] |=> !event_q[DLIS_BIT_RX_EOM])
    else $error("receive complete bit not cleared by read");

  a_fcs_clear: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    status_rd && !event_in[DLIS_BIT_FCS] |=> !event_q[DLIS_BIT_FCS])
    else $error("frame check bit not cleared by read");

  a_abort_clear: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    status_rd && !event_in[DLIS_BIT_ABORT] |=> !event_q[DLIS_BIT_ABORT])
    else $error("abort bit not cleared by read");

  a_idle_clear: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    status_rd && !event_in[DLIS_BIT_IDLE] |=> !event_q[DLIS_BIT_IDLE])
    else $error("flag octet bit not cleared by read");

  a_tx_eom_clear: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    status_rd && !event_in[DLIS_BIT_TX_EOM] |=> !event_q[DLIS_BIT_TX_EOM])
    else $error("transmit complete bit not cleared by read");

  a_rx_som_clear: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    status_rd && !event_in[DLIS_BIT_RX_SOM] |=> !event_q[DLIS_BIT_RX_SOM])
    else $error("receive begin bit not cleared by read");

  a_tx_som_clear: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    status_rd && !event_in[DLIS_BIT_TX_SOM] |=> !event_q[DLIS_BIT_TX_SOM])
    else $error("transmit begin bit not cleared by read");

  a_read_next: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    status_rd |=> (event_q == $past(event_in)))
    else $error("status after read differs from new events");

  a_no_phantom: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    1'b1 |=> ((event_q & ~$past(event_q) & ~$past(event_in)) == 7'h00))
    else $error("status bit set without its event");

  // ----------------------------------------------------------------
  // interrupt gating
  // ----------------------------------------------------------------
  a_tx_som_gate: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    event_q[DLIS_BIT_TX_SOM] && enable_q[DLIS_BIT_TX_SOM] |-> o_data_link_irq)
    else $error("enabled transmit begin gave no interrupt");

  a_rx_som_gate: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    event_q[DLIS_BIT_RX_SOM] && enable_q[DLIS_BIT_RX_SOM] |-> o_data_link_irq)
    else $error("enabled receive begin gave no interrupt");

  a_tx_eom_gate: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    event_q[DLIS_BIT_TX_EOM] && enable_q[DLIS_BIT_TX_EOM] |-> o_data_link_irq)
    else $error("enabled transmit complete gave no interrupt");

  a_rx_eom_gate: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    event_q[DLIS_BIT_RX_EOM] && enable_q[DLIS_BIT_RX_EOM] |-> o_data_link_irq)
    else $error("enabled receive complete gave no interrupt");

  a_fcs_gate: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    event_q[DLIS_BIT_FCS] && enable_q[DLIS_BIT_FCS] |-> o_data_link_irq)
    else $error("enabled frame check event gave no interrupt");

  a_abort_gate: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    event_q[DLIS_BIT_ABORT] && enable_q[DLIS_BIT_ABORT] |-> o_data_link_irq)
    else $error("enabled abort event gave no interrupt");

  a_idle_gate: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    event_q[DLIS_BIT_IDLE] && enable_q[DLIS_BIT_IDLE] |-> o_data_link_irq)
    else $error("enabled flag octet event gave no interrupt");

  a_irq_drop: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    status_rd && (event_in == 7'h00) |=> !o_data_link_irq)
    else $error("interrupt stayed after clearing read");

  a_irq_rise: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (|(event_in & enable_d)) |=> o_data_link_irq)
    else $error("enabled event gave no interrupt");

endmodule // dlis_top

// [tb/dlis_top_test.sv]
// self-checking bench for the data link event status and enable registers
`timescale 1ns/1ps
module dlis_top_test;
  import dlis_pkg::*;
  logic clk, rst, wr, rd, irq, mtype;
  logic [7:0] addr, wdata, rdata, d;
  logic [6:0] ev;
  int errors, total_checks, cyc;
  dlis_top dut (.i_core_clk(clk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_rx_message_complete(ev[3]),
    .i_frame_check_mismatch(ev[2]), .i_rx_abort_seen(ev[1]), .i_rx_flag_octet_seen(ev[0]),
    .i_tx_message_complete(ev[4]), .i_rx_message_begin(ev[5]), .i_tx_message_begin(ev[6]),
    .i_rx_msg_type(mtype), .o_data_link_irq(irq));
  // ----------------------------------------------------------------
  // bus and compare helpers
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic pulse(input logic [6:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 7'h00;
    #1;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rreg(DLIS_STATUS_OFS);
    chk("status", 8'h00, d);
    rreg(DLIS_ENABLE_OFS);
    chk("enable", 8'h00, d);
  endtask
  task automatic t_bits();
    logic [6:0] m;
    for (int b = 0; b < 7; b++) begin
      m = 7'h01 << b;
      pulse(m);
      chk("irq masked", 8'h00, {7'h00, irq});
      rreg(DLIS_STATUS_OFS);
      chk("status set", {1'b0, m}, d);
      rreg(DLIS_STATUS_OFS);
      chk("status cleared", 8'h00, d);
      wreg(DLIS_ENABLE_OFS, {1'b0, m});
      pulse(m);
      chk("irq on", 8'h01, {7'h00, irq});
      rreg(DLIS_STATUS_OFS);
      chk("irq off", 8'h00, {7'h00, irq});
      wreg(DLIS_ENABLE_OFS, 8'h00);
    end
  endtask
  task automatic t_misc();
    wreg(DLIS_ENABLE_OFS, 8'hFF);
    rreg(DLIS_ENABLE_OFS);
    chk("enable bit 7", 8'h7F, d);
    rreg(8'h05);
    chk("unmapped", 8'h00, d);
    @(posedge clk);
    addr <= DLIS_STATUS_OFS;
    rd <= 1'b1;
    ev <= 7'h01;
    @(posedge clk);
    rd <= 1'b0;
    ev <= 7'h00;
    #1 chk("late event", 8'h00, rdata);
    chk("late irq", 8'h01, {7'h00, irq});
    rreg(DLIS_STATUS_OFS);
    chk("kept event", 8'h01, d);
    pulse(7'h7F);
    rreg(DLIS_STATUS_OFS);
    chk("all events", 8'h7F, d);
    wreg(DLIS_ENABLE_OFS, 8'h00);
    @(posedge clk);
    mtype <= 1'b1;
    wreg(DLIS_STATUS_OFS, 8'h7F);
    wreg(8'h05, 8'hFF);
    rreg(DLIS_STATUS_OFS);
    chk("status write ignored", 8'h80, d);
    rreg(DLIS_ENABLE_OFS);
    chk("unmapped write ignored", 8'h00, d);
    @(posedge clk);
    mtype <= 1'b0;
  endtask
  task automatic t_midreset();
    wreg(DLIS_ENABLE_OFS, 8'h7F);
    pulse(7'h7F);
    chk("irq before reset", 8'h01, {7'h00, irq});
    @(posedge clk);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    #1 chk("irq after reset", 8'h00, {7'h00, irq});
    t_reset();
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      report_and_stop();
    end
  end
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    mtype = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    ev = 7'h00;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_bits();
    t_misc();
    t_midreset();
    report_and_stop();
  end
endmodule // dlis_top_test
